// *** shared/gdr_cfg.svh ***
`ifndef GDR_CFG_SVH
`define GDR_CFG_SVH
// register addresses
`define GDR_ADDR_STAT_ONE 4'h0
`define GDR_ADDR_STAT_TWO 4'h1
`define GDR_ADDR_DRV_CTRL 4'h2
`define GDR_ADDR_HS_DRIVE 4'h3
// frame layout
`define GDR_FRAME_BITS 16
`define GDR_RW_BIT 15
`define GDR_ADDR_HI 14
`define GDR_ADDR_LO 11
`define GDR_DATA_HI 10
// status one fields
`define GDR_S1_FAULT 10
`define GDR_S1_DS_OCP 9
`define GDR_S1_GDF 8
`define GDR_S1_SUPPLY_UNDERVOLTAGE_LOCKOUT 7
`define GDR_S1_OVERTEMP_SHUTDOWN 6
// status two fields
`define GDR_S2_AMP_HI 10
`define GDR_S2_AMP_LO 8
`define GDR_S2_OTW 7
`define GDR_S2_PUV 6
// driver control fields
`define GDR_DC_PUV_OFF 9
`define GDR_DC_GDF_OFF 8
`define GDR_DC_WARN_REP 7
`define GDR_DC_MODE_HI 6
`define GDR_DC_MODE_LO 5
`define GDR_DC_FREEWHEEL 4
`define GDR_DC_DIR 3
`define GDR_DC_ALL_SWITCHES_OFF 2
`define GDR_DC_BRAKE 1
`define GDR_DC_CLEAR 0
`define GDR_DC_LOCKED_MASK 11'h007
// high side register fields
`define GDR_HS_LOCK_HI 10
`define GDR_HS_LOCK_LO 8
`define GDR_LOCK_ON 3'h6
`define GDR_LOCK_OFF 3'h3
// reset values
`define GDR_DC_RESET 11'h000
`define GDR_HS_RESET 11'h3ff
`endif

// *** shared/gdr_pkg.sv ***
package gdr_pkg;
	typedef enum logic [1:0]
	{
		GDR_MODE_SIX = 2'b00,
		GDR_MODE_THREE = 2'b01,
		GDR_MODE_SINGLE = 2'b10,
		GDR_MODE_INDEP = 2'b11
	} gdr_mode_t;
	// raw detector inputs, one level per condition
	typedef struct packed
	{
		logic ds_overcurrent_a_high;
		logic ds_overcurrent_a_low;
		logic ds_overcurrent_b_high;
		logic ds_overcurrent_b_low;
		logic ds_overcurrent_c_high;
		logic ds_overcurrent_c_low;
		logic gate_fault_a_high;
		logic gate_fault_a_low;
		logic gate_fault_b_high;
		logic gate_fault_b_low;
		logic gate_fault_c_high;
		logic gate_fault_c_low;
		logic amp_a_overcurrent;
		logic amp_b_overcurrent;
		logic amp_c_overcurrent;
		logic overtemp_warning;
		logic pump_undervoltage;
		logic supply_undervoltage_lockout;
		logic overtemp_shutdown;
	} gdr_det_t;
	// settings handed to the pwm input logic
	typedef struct packed
	{
		gdr_mode_t mode;
		logic single_input_freewheel_select;
		logic direction;
		logic all_switches_off;
		logic brake;
	} gdr_pwm_cfg_t;
	typedef enum logic [1:0]
	{
		GDR_ST_IDLE = 2'b00,
		GDR_ST_SHIFT = 2'b01,
		GDR_ST_DONE = 2'b10
	} gdr_state_t;
endpackage

// *** src/gdr_regs.sv ***
`timescale 1ns/1ns
`include "gdr_cfg.svh"
// Overview of operation
// - status registers read-only, flags reset zero
// - status bit ten ORs faults, drives pin
// - summary bits overcurrent, gate, undervoltage, overtemp
// - per-switch drain-source overcurrent bits five..zero
// - amplifier overcurrent bits on sense variants
// - warning bit seven, pump undervoltage six
// - per-switch gate fault bits five..zero
// - bit nine disables pump undervoltage detection
// - bit eight disables gate fault detection
// - bit seven routes warning to fault
// - mode field selects pwm input scheme
// - bit four picks freewheel in single mode
// - direction is bit three OR pin
// - all_switches_off bit turns all switches off
// - brake bit or pin enables low sides, in single mode only
// - clear bit wipes latched flags, self-clears
// - lock code locks all but few bits
// - unlock code unlocks; lock resets unlocked
// - other codes ignored while unlocked
// - other codes ignored while locked
// - frame is flag, address, eleven data
// - write returns prior register content
// - reserved bits reset to zero
module gdr_regs #(
	parameter bit HAS_SENSE_AMPS = 1'b1
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic scs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire gdr_pkg::gdr_det_t det,
	input wire logic phase_c_high_input_pin,
	input wire logic phase_c_low_input_pin,
	output logic fault_indicator_pin_o,
	output logic fault_indicator_pin_oe,
	output gdr_pkg::gdr_pwm_cfg_t pwm_cfg,
	output logic [3:0] high_side_source_current_code,
	output logic [3:0] high_side_sink_current_code
);
	localparam int FB = `GDR_FRAME_BITS;
	logic rst_meta;
	logic rst_sync;
	logic [2:0] sclk_s;
	logic [1:0] scs_s;
	logic [1:0] sdi_s;
	logic sclk_d;
	logic [FB-1:0] sh_reg;
	logic [4:0] cnt_reg;
	logic [10:0] tx_reg;
	gdr_pkg::gdr_state_t st_reg;
	logic [10:0] s1_flags_reg;
	logic [10:0] s2_flags_reg;
	logic [10:0] dc_reg;
	logic [10:0] hs_reg;
	logic locked_reg;
	logic clr_now;
	logic sclk_fall;
	logic sclk_rise;
	logic frame_end;
	logic wr_ok;
	logic [10:0] s1_view;
	logic [10:0] sel_data;
	logic [3:0] f_addr;
	logic [10:0] f_data;
	logic fault_any;
	logic [10:0] s1_set;
	logic [10:0] s2_set;

	initial
	begin
		if (FB != 16)
			$error("frame length must be sixteen");
	end

	// reset released through two flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// pin synchronisers; third sclk stage is only for edge detection
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			sclk_s <= 3'h0;
			scs_s <= 2'h3;
			sdi_s <= 2'h0;
		end
		else
		begin
			sclk_s <= {sclk_s[1:0], sclk};
			scs_s <= {scs_s[0], scs_n};
			sdi_s <= {sdi_s[0], sdi};
		end
	end

	assign sclk_d = sclk_s[2];
	assign sclk_fall = sclk_d & ~sclk_s[1];
	assign sclk_rise = ~sclk_d & sclk_s[1];

	function automatic logic [10:0] reg_read(input logic [3:0] a, input logic [10:0] s1,
		input logic [10:0] s2, input logic [10:0] dc, input logic [10:0] hs);
		case (a)
			`GDR_ADDR_STAT_ONE: reg_read = s1;
			`GDR_ADDR_STAT_TWO: reg_read = s2;
			`GDR_ADDR_DRV_CTRL: reg_read = dc;
			`GDR_ADDR_HS_DRIVE: reg_read = hs;
			default: reg_read = 11'h000;
		endcase
	endfunction

	// frame fields taken from the shift register
	assign f_addr = sh_reg[`GDR_ADDR_HI:`GDR_ADDR_LO];
	assign f_data = sh_reg[`GDR_DATA_HI:0];
	assign frame_end = (st_reg == gdr_pkg::GDR_ST_SHIFT) && scs_s[1] && (cnt_reg == 5'(FB));
	assign wr_ok = frame_end && !sh_reg[`GDR_RW_BIT];
	// at the fifth fall the last address bit is still on the pin, not yet in the shifter
	assign sel_data = reg_read({sh_reg[2:0], sdi_s[1]}, s1_view, s2_flags_reg,
		dc_reg, hs_reg);

	// serial frame engine; a short or long frame is dropped on deselect
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			st_reg <= gdr_pkg::GDR_ST_IDLE;
			cnt_reg <= 5'h00;
			sh_reg <= 16'h0000;
			tx_reg <= 11'h000;
		end
		else
		begin
			case (st_reg)
				gdr_pkg::GDR_ST_IDLE:
				begin
					cnt_reg <= 5'h00;
					tx_reg <= 11'h000;
					if (!scs_s[1])
						st_reg <= gdr_pkg::GDR_ST_SHIFT;
				end
				gdr_pkg::GDR_ST_SHIFT:
				begin
					if (scs_s[1])
						st_reg <= gdr_pkg::GDR_ST_DONE;
					else if (sclk_fall)
					begin
						sh_reg <= {sh_reg[FB-2:0], sdi_s[1]};
						if (cnt_reg != 5'h1f)
							cnt_reg <= cnt_reg + 5'h01;
						// after the fifth bit the address is known: load old content
						if (cnt_reg == 5'h04)
							tx_reg <= sel_data;
					end
					else if (sclk_rise && cnt_reg > 5'h05)
						tx_reg <= {tx_reg[9:0], 1'b0};
				end
				gdr_pkg::GDR_ST_DONE:
					st_reg <= gdr_pkg::GDR_ST_IDLE;
				default:
					st_reg <= gdr_pkg::GDR_ST_IDLE;
			endcase
		end
	end

	// output driven only while selected; msb first, don't-care bits low
	assign sdo = (cnt_reg >= 5'h05) ? tx_reg[10] : 1'b0;
	assign sdo_oe = !scs_s[1] && (st_reg == gdr_pkg::GDR_ST_SHIFT);

	// driver control and lock handling
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			dc_reg <= `GDR_DC_RESET;
			hs_reg <= `GDR_HS_RESET;
			locked_reg <= 1'b0;
		end
		else
		begin
			dc_reg[`GDR_DC_CLEAR] <= 1'b0;
			if (wr_ok && f_addr == `GDR_ADDR_DRV_CTRL)
			begin
				if (locked_reg)
					dc_reg <= (dc_reg & ~`GDR_DC_LOCKED_MASK) | (f_data & `GDR_DC_LOCKED_MASK);
				else
					dc_reg <= f_data;
			end
			if (wr_ok && f_addr == `GDR_ADDR_HS_DRIVE)
			begin
				if (!locked_reg)
					hs_reg[`GDR_HS_LOCK_LO-1:0] <= f_data[`GDR_HS_LOCK_LO-1:0];
				hs_reg[`GDR_HS_LOCK_HI:`GDR_HS_LOCK_LO] <= f_data[`GDR_HS_LOCK_HI:`GDR_HS_LOCK_LO];
				if (f_data[`GDR_HS_LOCK_HI:`GDR_HS_LOCK_LO] == `GDR_LOCK_ON)
					locked_reg <= 1'b1;
				else if (f_data[`GDR_HS_LOCK_HI:`GDR_HS_LOCK_LO] == `GDR_LOCK_OFF)
					locked_reg <= 1'b0;
			end
		end
	end

	assign clr_now = dc_reg[`GDR_DC_CLEAR];

	// detector sets, gated by the disable bits
	always_comb
	begin
		s1_set = 11'h000;
		s2_set = 11'h000;
		s1_set[5:0] = {det.ds_overcurrent_a_high, det.ds_overcurrent_a_low,
			det.ds_overcurrent_b_high, det.ds_overcurrent_b_low,
			det.ds_overcurrent_c_high, det.ds_overcurrent_c_low};
		s1_set[`GDR_S1_OVERTEMP_SHUTDOWN] = det.overtemp_shutdown;
		s1_set[`GDR_S1_SUPPLY_UNDERVOLTAGE_LOCKOUT] = det.supply_undervoltage_lockout;
		if (!dc_reg[`GDR_DC_GDF_OFF])
			s2_set[5:0] = {det.gate_fault_a_high, det.gate_fault_a_low,
				det.gate_fault_b_high, det.gate_fault_b_low,
				det.gate_fault_c_high, det.gate_fault_c_low};
		s2_set[`GDR_S2_OTW] = det.overtemp_warning;
		s2_set[`GDR_S2_PUV] = det.pump_undervoltage & ~dc_reg[`GDR_DC_PUV_OFF];
		if (HAS_SENSE_AMPS)
			s2_set[`GDR_S2_AMP_HI:`GDR_S2_AMP_LO] = {det.amp_a_overcurrent,
				det.amp_b_overcurrent, det.amp_c_overcurrent};
	end

	// latched flags; a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			s1_flags_reg <= 11'h000;
			s2_flags_reg <= 11'h000;
		end
		else
		begin
			s1_flags_reg <= (clr_now ? 11'h000 : s1_flags_reg) | s1_set;
			s2_flags_reg <= (clr_now ? 11'h000 : s2_flags_reg) | s2_set;
		end
	end

	// summary view: bits nine and eight summarise the per-switch groups
	assign fault_any = (|s1_flags_reg[`GDR_S1_DS_OCP - 1:0]) | (|s2_flags_reg[5:0])
		| s2_flags_reg[`GDR_S2_PUV] | (|s2_flags_reg[`GDR_S2_AMP_HI:`GDR_S2_AMP_LO])
		| (s2_flags_reg[`GDR_S2_OTW] & dc_reg[`GDR_DC_WARN_REP]);
	always_comb
	begin
		s1_view = s1_flags_reg;
		s1_view[`GDR_S1_DS_OCP] = |s1_flags_reg[5:0];
		s1_view[`GDR_S1_GDF] = |s2_flags_reg[5:0];
		s1_view[`GDR_S1_FAULT] = fault_any;
	end

	// open-drain fault pin pulls low while any fault stands
	assign fault_indicator_pin_o = 1'b0;
	assign fault_indicator_pin_oe = fault_any;

	// pwm configuration outputs
	always_comb
	begin
		pwm_cfg.mode = gdr_pkg::gdr_mode_t'(dc_reg[`GDR_DC_MODE_HI:`GDR_DC_MODE_LO]);
		pwm_cfg.single_input_freewheel_select = dc_reg[`GDR_DC_FREEWHEEL];
		pwm_cfg.direction = dc_reg[`GDR_DC_DIR] | phase_c_high_input_pin;
		pwm_cfg.all_switches_off = dc_reg[`GDR_DC_ALL_SWITCHES_OFF];
		pwm_cfg.brake = (pwm_cfg.mode == gdr_pkg::GDR_MODE_SINGLE)
			&& (dc_reg[`GDR_DC_BRAKE] | phase_c_low_input_pin);
	end

	assign high_side_source_current_code = hs_reg[7:4];
	assign high_side_sink_current_code = hs_reg[3:0];
endmodule

// *** tb/gdr_master.sv ***
`timescale 1ns/1ns
// serial master; five clk per phase keeps every edge clear of the pin synchronisers
module gdr_master
(
	input wire logic clk,
	output logic sclk,
	output logic scs_n,
	output logic sdi,
	input wire logic sdo
);
	// idle: deselected, clock low
	initial
	begin
		sclk = 1'b0;
		scs_n = 1'b1;
		sdi = 1'b0;
	end
	// one frame of exactly 16 clocks, msb first
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(negedge clk) scs_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			sdi = w[i];
			repeat (5) @(negedge clk);
			sclk = 1'b1;
			repeat (5) @(negedge clk);
			r[i] = sdo;
			sclk = 1'b0;
			repeat (5) @(negedge clk);
		end
		scs_n = 1'b1;
		// released data line must not look like the last bit
		sdi = ~sdi;
		repeat (60) @(negedge clk);
	endtask
endmodule

// *** tb/gdr_regs_assertions.sv ***
`timescale 1ns/1ns
module gdr_regs_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scs_n,
	input wire logic sdo_oe,
	input wire gdr_pkg::gdr_det_t det,
	input wire logic phase_c_high_input_pin,
	input wire logic phase_c_low_input_pin,
	input wire logic fault_indicator_pin_o,
	input wire logic fault_indicator_pin_oe,
	input wire gdr_pkg::gdr_pwm_cfg_t pwm_cfg,
	input wire logic [3:0] high_side_source_current_code,
	input wire logic [3:0] high_side_sink_current_code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// eight quiet cycles put any pending write or clear behind us
	sequence idle_s;
		scs_n [*8];
	endsequence
	pin_low_a: assert property (!fault_indicator_pin_o)
		else $error("fault pin driven high");
	reset_vals_a: assert property ($rose(rst_n) |-> !fault_indicator_pin_oe &&
		high_side_source_current_code == 4'hf && high_side_sink_current_code == 4'hf)
		else $error("bad reset state");
	flag_sets_a: assert property (det.overtemp_shutdown |-> ##[1:4] fault_indicator_pin_oe)
		else $error("fault not raised");
	flag_holds_a: assert property (idle_s ##0 fault_indicator_pin_oe |=> fault_indicator_pin_oe)
		else $error("flag dropped without clear");
	cfg_stable_a: assert property (idle_s |=> $stable(pwm_cfg.mode) &&
		$stable(high_side_source_current_code)) else $error("config moved");
	dir_pin_a: assert property (pwm_cfg.mode == gdr_pkg::GDR_MODE_SINGLE &&
		phase_c_high_input_pin |-> pwm_cfg.direction) else $error("direction pin lost");
	brake_pin_a: assert property (pwm_cfg.mode == gdr_pkg::GDR_MODE_SINGLE &&
		phase_c_low_input_pin |-> pwm_cfg.brake) else $error("brake pin lost");
	sdo_hiz_a: assert property (scs_n [*3] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	cover property (fault_indicator_pin_oe);
	cover property (pwm_cfg.brake && pwm_cfg.mode == gdr_pkg::GDR_MODE_SINGLE);
	cover property (sdo_oe);
endmodule
bind gdr_regs gdr_regs_chk i_chk (.clk, .rst_n, .scs_n, .sdo_oe, .det, .phase_c_high_input_pin,
	.phase_c_low_input_pin, .fault_indicator_pin_o, .fault_indicator_pin_oe, .pwm_cfg,
	.high_side_source_current_code, .high_side_sink_current_code);

// *** tb/gdr_regs_tb.sv ***
`timescale 1ns/1ns
module gdr_regs_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, scs_n, sdi, sdo, sdo_oe, f_o, f_oe;
	logic dir_pin = 1'b0;
	logic brk_pin = 1'b0;
	logic [18:0] det = '0;
	gdr_pkg::gdr_pwm_cfg_t cfg;
	logic [3:0] src, snk;
	logic [15:0] rd;
	int error_cnt = 0;
	int cmp_count = 0;
	// 125 MHz
	always #4 clk = ~clk;
	gdr_regs i_gdr_regs (.clk(clk), .rst_n(rst_n), .sclk(sclk), .scs_n(scs_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .det(det), .phase_c_high_input_pin(dir_pin),
		.phase_c_low_input_pin(brk_pin), .fault_indicator_pin_o(f_o),
		.fault_indicator_pin_oe(f_oe), .pwm_cfg(cfg), .high_side_source_current_code(src),
		.high_side_sink_current_code(snk));
	gdr_master i_gdr_master (.clk(clk), .sclk(sclk), .scs_n(scs_n), .sdi(sdi), .sdo(sdo));
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [10:0] d);
		i_gdr_master.xfer({1'b0, a, d}, rd);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [10:0] e);
		i_gdr_master.xfer({1'b1, a, 11'h000}, rd);
		chk(rd[10:0], e);
	endtask
	// one-cycle detector pulse; flags must latch it
	task automatic hit(input logic [18:0] d);
		@(negedge clk) det = d;
		@(negedge clk) det = '0;
	endtask
	task automatic test_done();
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		for (int a = 0; a < 5; a++)
			rdc(a[3:0], a == 3 ? 11'h3ff : 11'h000);
		wr(4'h0, 11'h7ff);
		rdc(4'h0, 11'h000);
		for (int m = 0; m < 4; m++)
		begin
			wr(4'h2, {4'h0, m[1:0], 5'h00});
			chk(cfg.mode, m[1:0]);
		end
		wr(4'h2, 11'h05c);
		chk(rd[10:0], 11'h060);
		chk(cfg, 11'h02e);
		wr(4'h2, 11'h042);
		chk(cfg, 11'h021);
		wr(4'h2, 11'h040);
		dir_pin = 1'b1;
		brk_pin = 1'b1;
		@(negedge clk) chk(cfg, 11'h025);
		dir_pin = 1'b0;
		brk_pin = 1'b0;
		hit(19'h080c9);
		rdc(4'h0, 11'h744);
		rdc(4'h1, 11'h481);
		chk(f_oe, 1'b1);
		wr(4'h2, 11'h041);
		rdc(4'h0, 11'h000);
		rdc(4'h2, 11'h040);
		wr(4'h2, 11'h340);
		hit(19'h01004);
		rdc(4'h1, 11'h000);
		wr(4'h2, 11'h0c0);
		hit(19'h00008);
		rdc(4'h0, 11'h400);
		wr(4'h2, 11'h040);
		rdc(4'h0, 11'h000);
		chk(f_oe, 1'b0);
		wr(4'h3, 11'h6ab);
		chk({src, snk}, 11'h0ab);
		wr(4'h3, 11'h5ff);
		chk({src, snk}, 11'h0ab);
		wr(4'h2, 11'h3ff);
		rdc(4'h2, 11'h046);
		wr(4'h3, 11'h3ff);
		wr(4'h3, 11'h155);
		chk({src, snk}, 11'h055);
		wr(4'h2, 11'h000);
		rdc(4'h2, 11'h000);
		test_done();
	end
	// watchdog well beyond the roughly eighty microseconds the tests need
	initial
	begin
		#500000;
		error_cnt++;
		test_done();
	end
endmodule
